/* serial_bus_master.sv */
// Behavioural master on the far side of the pin clock and data lines.
// Assumes the bench resolves both lines with pull-ups; releasing drives 1.
`timescale 1ns/1ps
module serial_bus_master
(
   input wire logic mclk_i,
   input wire logic scl_i,
   output logic scl_o,
   output logic sda_o
);
   // Both lines idle released
   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // Six mclk per half period keeps the pin clock well under mclk/4
   task automatic half_wait();
      repeat (6) @(posedge mclk_i);
      #1;
   endtask
   // Data moves with the clock high for start and stop
   task automatic set_sda(input logic b);
      sda_o = b;
      half_wait();
   endtask
   task automatic scl_low();
      scl_o = 1'b0;
      half_wait();
   endtask
   // A slave may stretch, so report whether the line really rose
   task automatic scl_high(output logic ok);
      scl_o = 1'b1;
      half_wait();
      ok = scl_i;
   endtask
   task automatic send_bit(input logic b, output logic ok);
      sda_o = b;
      half_wait();
      scl_high(ok);
      scl_low();
   endtask
endmodule

/* serial_shift_pkg.sv */
// Constants and carrier types for the universal serial shift unit.
// Assumes an 8-bit processor data bus with byte addresses and one-cycle strobes.
package serial_shift_pkg;
   // Register byte addresses
   localparam logic [7:0] CTRL_ADDR = 8'hB8;
   localparam logic [7:0] STATUS_ADDR = 8'hB9;
   localparam logic [7:0] DATA_ADDR = 8'hBA;
   // Control register field positions
   localparam int CTRL_START_IE = 7;
   localparam int CTRL_OVF_IE = 6;
   localparam int CTRL_WM_HI = 5;
   localparam int CTRL_WM_LO = 4;
   localparam int CTRL_CS_EXT = 3;
   localparam int CTRL_CS_EDGE = 2;
   localparam int CTRL_CLK_STROBE = 1;
   localparam int CTRL_TOGGLE = 0;
   // Status register field positions
   localparam int STAT_START = 7;
   localparam int STAT_OVF = 6;
   localparam int STAT_STOP = 5;
   // Reset values, counter maximum and acknowledge preload
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [3:0] CNT_MAX = 4'hF;
   localparam logic [3:0] CNT_ACK_PRELOAD = 4'hE;
   // Wire modes
   localparam logic [1:0] WM_OFF = 2'h0;
   localparam logic [1:0] WM_THREE = 2'h1;
   localparam logic [1:0] WM_TWO = 2'h2;
   localparam logic [1:0] WM_TWO_OVF_HOLD = 2'h3;
   // Start detector data delay window and link clock period
   localparam int SDA_DELAY_MIN_NS = 50;
   localparam int SDA_DELAY_MAX_NS = 300;
   localparam int LINK_PERIOD_NS = 6;
   localparam int SDA_DELAY_STAGES = (SDA_DELAY_MIN_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
   // Serial clock ceiling as a divisor of the system clock
   localparam int SCK_DIVISOR_MIN = 4;

   typedef struct packed {
      logic start_ie;
      logic ovf_ie;
      logic [1:0] wire_mode_select;
      logic clock_source_external;
      logic clock_edge_select;
      logic clock_strobe_select;
   } ctrl_t;

   typedef struct packed {
      logic start_flag;
      logic overflow_flag;
      logic stop_flag;
   } flags_t;
endpackage

/* serial_shift_unit.sv */
// Universal serial shift unit: shift register, edge counter, output latch,
// two-wire clock hold and an asynchronous start/stop detector.
// Assumes pins pass through port logic outside; pin inputs are asynchronous,
// link_clk_i is a free-running sampling clock for the start detector.
//
// Overview of operation
// - In two-wire mode a detected start condition sets the start flag.
// - After start, first falling clock edge makes the unit hold clock low.
// - Two-wire slave samples data and shifts it in on rising clock edges.
// - After eight bits the counter overflows; in mode 11 clock is also forced low.
// - Preloading counter with 14 gives a one-bit acknowledge then hold again.
// - Start detector works only while two-wire mode is selected.
// - Start detector runs without the system clock, enabling deep wake-up.
// - Data into start detector is delayed 50 to 300 ns.
// - Serial clock must not exceed a quarter of the system clock.
// - With external clock and strobe select low the counter counts both pin edges.
// - A software data write in a shift cycle wins; no shift happens.
// - Shift left on external edge, timer match or software strobe.
// - Data-out or two-wire data driven from bit 7 via output latch.
// - Latch open first half-cycle on external clock, always on internal.
// - With latch open, a written new top bit reaches the pin at once.
// - Off or three-wire, external clock, strobe select low: any edge sets start.
// - Start flag clears by writing one; clearing releases start clock hold.
// - Overflow flag sets on 15 to 0 wrap; write one clears and releases hold.
// - Two-wire stop condition sets stop flag; write one clears; no interrupt.
// - Collision bit reads one when bit 7 differs from data pin level.
// - Mode 00 disables outputs, hold and detector; 01 is three-wire.
`timescale 1ns/1ps
module serial_shift_unit
#(
   parameter int DELAY_STAGES = serial_shift_pkg::SDA_DELAY_STAGES
)
(
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic link_clk_i,
   input wire logic [7:0] cpu_addr_i,
   input wire logic [7:0] cpu_wdata_i,
   input wire logic cpu_wr_i,
   input wire logic cpu_rd_i,
   output logic [7:0] cpu_rdata_o,
   input wire logic global_ie_i,
   input wire logic timer_match_i,
   input wire logic scl_out_en_i,
   input wire logic sda_out_en_i,
   input wire logic serial_data_in_i,
   input wire logic serial_clock_pin_i,
   output logic serial_clock_pin_o,
   output logic serial_clock_pin_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic data_out_o,
   output logic data_out_oe_o,
   output logic irq_o,
   output logic wake_o
);
   serial_shift_pkg::ctrl_t ctrl;
   serial_shift_pkg::flags_t flags;
   logic [7:0] shift_data_register;
   logic [3:0] edge_counter_value;
   logic out_latch;
   logic scl_port;
   logic hold_start;
   logic scl_s1, scl_s2, scl_s3;
   logic sda_s1, sda_s2;
   logic di_s1, di_s2;
   logic st_s1, st_s2, st_s3;
   logic sp_s1, sp_s2, sp_s3;
   logic wr_ctrl, wr_status, wr_data, clk_strobe, toggle_strobe;
   logic scl_rise, scl_fall, scl_edge, two_wire, data_in;
   logic shift_tick, count_tick, ovf_event, start_event, stop_event, latch_open;
   logic [7:0] next_shift;
   logic next_latch, output_collision, hold_ovf;
   // Event toggles from the link domain, read only through the synchronisers below
   logic start_tgl, stop_tgl;

   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
      addr_hit = (addr == reg_addr);
   endfunction

   // Bus strobes; bit 0 acts only in the cycle of the write, bit 1 is also stored as strobe select
   assign wr_ctrl = cpu_wr_i && addr_hit(cpu_addr_i, serial_shift_pkg::CTRL_ADDR);
   assign wr_status = cpu_wr_i && addr_hit(cpu_addr_i, serial_shift_pkg::STATUS_ADDR);
   assign wr_data = cpu_wr_i && addr_hit(cpu_addr_i, serial_shift_pkg::DATA_ADDR);
   assign clk_strobe = wr_ctrl && cpu_wdata_i[serial_shift_pkg::CTRL_CLK_STROBE];
   assign toggle_strobe = wr_ctrl && cpu_wdata_i[serial_shift_pkg::CTRL_TOGGLE];
   assign two_wire = ctrl.wire_mode_select[1];

   // Two-stage synchronisers for the pins; the third clock stage only feeds edge detection
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_s3 <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         di_s1 <= 1'b0;
         di_s2 <= 1'b0;
      end
      else
      begin
         scl_s1 <= serial_clock_pin_i;
         scl_s2 <= scl_s1;
         scl_s3 <= scl_s2;
         sda_s1 <= sda_i;
         sda_s2 <= sda_s1;
         di_s1 <= serial_data_in_i;
         di_s2 <= di_s1;
      end
   end

   // Pin edges are only seen cleanly if the serial clock stays below a quarter of mclk
   assign scl_rise = scl_s2 && !scl_s3;
   assign scl_fall = !scl_s2 && scl_s3;
   assign scl_edge = scl_rise || scl_fall;
   assign data_in = two_wire ? sda_s2 : di_s2;

   // Clock source select: pin edge, timer match or software strobe
   always_comb
   begin
      if (ctrl.clock_source_external)
      begin
         shift_tick = ctrl.clock_edge_select ? scl_fall : scl_rise;
         count_tick = ctrl.clock_strobe_select ? toggle_strobe : scl_edge;
      end
      else
      begin
         shift_tick = ctrl.clock_edge_select ? timer_match_i : clk_strobe;
         count_tick = shift_tick;
      end
   end

   // A write in the same cycle as a shift keeps the written value
   always_comb
   begin
      if (wr_data)
         next_shift = cpu_wdata_i;
      else if (shift_tick)
         next_shift = {shift_data_register[6:0], data_in};
      else
         next_shift = shift_data_register;
   end

   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         shift_data_register <= serial_shift_pkg::DATA_RESET;
      else
         shift_data_register <= next_shift;
   end

   // Edge counter; a software write of the count overrides a tick in that cycle
   assign ovf_event = count_tick && !wr_status && (edge_counter_value == serial_shift_pkg::CNT_MAX);
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         edge_counter_value <= 4'h0;
      else if (wr_status)
         edge_counter_value <= cpu_wdata_i[3:0]; // Preload 14 for a one-bit acknowledge
      else if (count_tick)
         edge_counter_value <= edge_counter_value + 4'h1;
   end

   // Output latch: open all the time on internal clock, first half-cycle on external
   assign latch_open = !ctrl.clock_source_external || (scl_s2 == ctrl.clock_edge_select);
   assign next_latch = latch_open ? next_shift[7] : out_latch;
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         out_latch <= 1'b1;
      else
         out_latch <= next_latch;
   end

   // Control register; strobe bits are not stored except the strobe select
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         ctrl <= serial_shift_pkg::CTRL_RESET[7:1];
      else if (wr_ctrl)
         ctrl <= cpu_wdata_i[7:1];
   end

   // Software clock pin level, toggled by the toggle strobe
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         scl_port <= 1'b1;
      else if (toggle_strobe)
         scl_port <= !scl_port;
   end

   // Start and stop events from the link domain, toggle crossings
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         st_s1 <= 1'b0;
         st_s2 <= 1'b0;
         st_s3 <= 1'b0;
         sp_s1 <= 1'b0;
         sp_s2 <= 1'b0;
         sp_s3 <= 1'b0;
      end
      else
      begin
         st_s1 <= start_tgl;
         st_s2 <= st_s1;
         st_s3 <= st_s2;
         sp_s1 <= stop_tgl;
         sp_s2 <= sp_s1;
         sp_s3 <= sp_s2;
      end
   end

   // Three-wire or off mode may use any pin edge as a start event
   assign start_event = (two_wire && (st_s2 != st_s3))
                        || (!two_wire && ctrl.clock_source_external && !ctrl.clock_strobe_select && scl_edge);
   assign stop_event = two_wire && (sp_s2 != sp_s3);

   // Sticky flags; a set in the clearing cycle wins
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         flags <= serial_shift_pkg::STATUS_RESET[7:5];
      else
      begin
         if (start_event)
            flags.start_flag <= 1'b1;
         else if (wr_status && cpu_wdata_i[serial_shift_pkg::STAT_START])
            flags.start_flag <= 1'b0;
         if (ovf_event)
            flags.overflow_flag <= 1'b1;
         else if (wr_status && cpu_wdata_i[serial_shift_pkg::STAT_OVF])
            flags.overflow_flag <= 1'b0;
         if (stop_event)
            flags.stop_flag <= 1'b1;
         else if (wr_status && cpu_wdata_i[serial_shift_pkg::STAT_STOP])
            flags.stop_flag <= 1'b0;
      end
   end

   // Hold after start begins at the first falling clock edge, ends with the flag
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         hold_start <= 1'b0;
      else
         hold_start <= two_wire && flags.start_flag && (hold_start || scl_fall);
   end

   // Overflow hold only in the two-wire mode with counter hold
   assign hold_ovf = (ctrl.wire_mode_select == serial_shift_pkg::WM_TWO_OVF_HOLD) && flags.overflow_flag;
   assign output_collision = shift_data_register[7] != sda_s2;

   // Pin drivers; mode 00 drives nothing, so the port logic keeps the pins
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         serial_clock_pin_o <= 1'b1;
         serial_clock_pin_oe_o <= 1'b0;
         sda_o <= 1'b0;
         sda_oe_o <= 1'b0;
         data_out_o <= 1'b1;
         data_out_oe_o <= 1'b0;
      end
      else
      begin
         serial_clock_pin_o <= two_wire ? 1'b0 : scl_port;
         serial_clock_pin_oe_o <= two_wire ? (hold_start || hold_ovf || (scl_out_en_i && !scl_port))
                                  : (ctrl.wire_mode_select == serial_shift_pkg::WM_THREE) && scl_out_en_i;
         sda_o <= 1'b0;
         sda_oe_o <= two_wire && sda_out_en_i && !next_latch;
         data_out_o <= next_latch;
         data_out_oe_o <= (ctrl.wire_mode_select == serial_shift_pkg::WM_THREE) && sda_out_en_i;
      end
   end

   // Interrupt request; the stop flag never requests
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         irq_o <= 1'b0;
      else
         irq_o <= global_ie_i && ((flags.start_flag && ctrl.start_ie) || (flags.overflow_flag && ctrl.ovf_ie));
   end

   // Registered read data, unmapped addresses read zero
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         cpu_rdata_o <= 8'h00;
      else if (cpu_rd_i)
      begin
         if (addr_hit(cpu_addr_i, serial_shift_pkg::CTRL_ADDR))
            cpu_rdata_o <= {ctrl[6:1], 2'h0};
         else if (addr_hit(cpu_addr_i, serial_shift_pkg::STATUS_ADDR))
            cpu_rdata_o <= {flags, output_collision, edge_counter_value};
         else if (addr_hit(cpu_addr_i, serial_shift_pkg::DATA_ADDR))
            cpu_rdata_o <= shift_data_register;
         else
            cpu_rdata_o <= 8'h00;
      end
   end

   // Link domain: start/stop detector, needs no system clock
   logic lk_scl1, lk_scl2, lk_sda1, lk_sda2, lk_en1, lk_en2;
   logic [DELAY_STAGES-1:0] sda_dly;

   // The delay line sits near the 50 ns end of the 50 to 300 ns window so clock is read when data settles
   always_ff @(posedge link_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         lk_scl1 <= 1'b1;
         lk_scl2 <= 1'b1;
         lk_sda1 <= 1'b1;
         lk_sda2 <= 1'b1;
         lk_en1 <= 1'b0;
         lk_en2 <= 1'b0;
         sda_dly <= '1;
      end
      else
      begin
         lk_scl1 <= serial_clock_pin_i;
         lk_scl2 <= lk_scl1;
         lk_sda1 <= sda_i;
         lk_sda2 <= lk_sda1;
         lk_en1 <= two_wire;
         lk_en2 <= lk_en1;
         sda_dly <= {sda_dly[DELAY_STAGES-2:0], lk_sda2};
      end
   end

   // Data falling while clock high is a start, rising is a stop
   always_ff @(posedge link_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         start_tgl <= 1'b0;
         stop_tgl <= 1'b0;
         wake_o <= 1'b0;
      end
      else
      begin
         if (lk_en2 && lk_scl2 && sda_dly[DELAY_STAGES-1] && !sda_dly[DELAY_STAGES-2])
            start_tgl <= !start_tgl;
         if (lk_en2 && lk_scl2 && !sda_dly[DELAY_STAGES-1] && sda_dly[DELAY_STAGES-2])
            stop_tgl <= !stop_tgl;
         wake_o <= lk_en2 && lk_scl2 && sda_dly[DELAY_STAGES-1] && !sda_dly[DELAY_STAGES-2];
      end
   end

   // ---- Checks
   sequence s_wrap;
      count_tick && !wr_status && edge_counter_value == 4'hF;
   endsequence
   sequence s_flag_up;
      flags.overflow_flag && ctrl.ovf_ie && global_ie_i;
   endsequence

   chk_ovf_wrap: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      s_wrap |=> flags.overflow_flag && edge_counter_value == 4'h0) else $error("overflow missed");
   chk_ovf_sticky: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      flags.overflow_flag && !wr_status |=> flags.overflow_flag) else $error("overflow flag lost");
   chk_write_wins: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      wr_data |=> shift_data_register == $past(cpu_wdata_i)) else $error("data write lost");
   chk_shift_left: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      shift_tick && !wr_data |=> shift_data_register == {$past(shift_data_register[6:0]), $past(data_in)})
      else $error("shift wrong");
   chk_ovf_hold: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      hold_ovf |=> serial_clock_pin_oe_o && !serial_clock_pin_o) else $error("overflow hold missing");
   chk_start_hold: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      two_wire && flags.start_flag && scl_fall ##1 two_wire && flags.start_flag |=> serial_clock_pin_oe_o)
      else $error("start hold missing");
   chk_mode_off: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (ctrl.wire_mode_select == 2'h0) [*2] |-> !serial_clock_pin_oe_o && !sda_oe_o && !data_out_oe_o)
      else $error("outputs driven in off mode");
   chk_latch_open: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      wr_data && !ctrl.clock_source_external |=> ##1 data_out_o == $past(cpu_wdata_i[7], 2))
      else $error("latch not transparent");
   chk_irq_level: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      s_flag_up |=> irq_o) else $error("irq missing");
   chk_stop_quiet: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      !flags.start_flag && !flags.overflow_flag |=> !irq_o) else $error("irq without flag");
   chk_sck_edge: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      !two_wire && ctrl.clock_source_external && !ctrl.clock_strobe_select && scl_edge |=> flags.start_flag)
      else $error("edge did not set start");
endmodule

/* serial_shift_unit_test.sv */
// Self-checking bench for the universal serial shift unit.
// Assumes serial_bus_master as the far side and pull-ups on both lines.
`timescale 1ns/1ps
module serial_shift_unit_test;
   localparam logic [7:0] ctrl_a = serial_shift_pkg::CTRL_ADDR;
   localparam logic [7:0] stat_a = serial_shift_pkg::STATUS_ADDR;
   localparam logic [7:0] data_a = serial_shift_pkg::DATA_ADDR;
   logic mclk = 1'b0;
   logic link_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic gie = 1'b0;
   logic tmr = 1'b0;
   logic din = 1'b0;
   logic tw = 1'b0;
   logic scl_en = 1'b1;
   logic sda_en = 1'b1;
   logic [7:0] rdata;
   logic scl_po, scl_oe, sda_o, sda_oe, dout, dout_oe, irq, wake;
   logic m_scl, m_sda, ok;
   logic wake_seen = 1'b0;
   int mismatches = 0;
   int compares = 0;
   int cycles = 0;
   // Open-drain lines: any party pulling low wins
   wire scl_wire = m_scl & ~(scl_oe & ~scl_po);
   wire sda_wire = m_sda & ~(sda_oe & ~sda_o);
   // Data in and two-wire data share one pin in two-wire mode
   wire din_pin = tw ? sda_wire : din;

   serial_shift_unit dut_u
   (
      .mclk_i(mclk), .reset_n_i(reset_n), .link_clk_i(link_clk),
      .cpu_addr_i(addr), .cpu_wdata_i(wdata), .cpu_wr_i(wr), .cpu_rd_i(rd),
      .cpu_rdata_o(rdata), .global_ie_i(gie), .timer_match_i(tmr),
      .scl_out_en_i(scl_en), .sda_out_en_i(sda_en), .serial_data_in_i(din_pin),
      .serial_clock_pin_i(scl_wire), .serial_clock_pin_o(scl_po),
      .serial_clock_pin_oe_o(scl_oe), .sda_i(sda_wire), .sda_o(sda_o),
      .sda_oe_o(sda_oe), .data_out_o(dout), .data_out_oe_o(dout_oe),
      .irq_o(irq), .wake_o(wake)
   );
   serial_bus_master m
   (
      .mclk_i(mclk), .scl_i(scl_wire), .scl_o(m_scl), .sda_o(m_sda)
   );

   initial
   begin
      forever #20 mclk = ~mclk;
   end
   // Link clock is free running and unrelated in phase
   initial
   begin
      #1.7;
      forever #3 link_clk = ~link_clk;
   end
   // The wake pulse lasts one link cycle, so it is caught in its own domain
   always @(posedge link_clk)
   begin
      if (wake === 1'b1)
         wake_seen <= 1'b1;
   end
   // Hang guard
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("counts: %0d mismatches, %0d compares", mismatches, compares);
      if (mismatches == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string s);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, s, got, exp);
      end
   endtask
   task automatic check1(input logic got, input logic exp, input string s);
      check8({7'h00, got}, {7'h00, exp}, s);
   endtask
   task automatic pause(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      pause(1);
      addr = a;
      wdata = d;
      wr = 1'b1;
      pause(1);
      wr = 1'b0;
   endtask
   task automatic reg_read(input logic [7:0] a, output logic [7:0] v);
      pause(1);
      addr = a;
      rd = 1'b1;
      pause(1);
      rd = 1'b0;
      v = rdata;
   endtask
   // Collision bit is masked; it only means something in two-wire mode
   task automatic chk_stat(input logic [7:0] exp, input string s);
      logic [7:0] v;
      reg_read(stat_a, v);
      check8(v & 8'hEF, exp, s);
   endtask

   task automatic t_reset();
      logic [7:0] v;
      reg_read(ctrl_a, v);
      check8(v, 8'h00, "control reset");
      reg_read(data_a, v);
      check8(v, 8'h00, "data reset");
      chk_stat(8'h00, "status reset");
      reg_write(8'hC0, 8'hFF);
      reg_read(8'hC0, v);
      check8(v, 8'h00, "unmapped read");
      $display("test reset done");
   endtask
   task automatic t_soft();
      logic [7:0] v;
      din = 1'b1;
      reg_write(ctrl_a, 8'h10);
      reg_write(data_a, 8'h35);
      pause(2);
      check1(dout_oe, 1'b1, "three-wire out enable");
      check1(dout, 1'b0, "msb zero out");
      check1(scl_oe, 1'b1, "three-wire clock enable");
      scl_en = 1'b0;
      sda_en = 1'b0;
      pause(2);
      check1(dout_oe | scl_oe, 1'b0, "port directions off");
      scl_en = 1'b1;
      sda_en = 1'b1;
      reg_write(data_a, 8'h80);
      pause(1);
      check1(dout, 1'b1, "new msb at once");
      reg_write(data_a, 8'h35);
      reg_write(stat_a, 8'hE0);
      repeat (3) reg_write(ctrl_a, 8'h12);
      reg_read(data_a, v);
      check8(v, 8'hAF, "strobe shift");
      chk_stat(8'h03, "strobe count");
      check1(dout, 1'b1, "latch open internal");
      reg_write(stat_a, 8'h0F);
      reg_write(ctrl_a, 8'h12);
      chk_stat(8'h40, "wrap flag");
      reg_write(ctrl_a, 8'h50);
      gie = 1'b1;
      pause(2);
      check1(irq, 1'b1, "irq on");
      gie = 1'b0;
      pause(2);
      check1(irq, 1'b0, "irq masked");
      gie = 1'b1;
      reg_write(stat_a, 8'h40);
      pause(2);
      check1(irq, 1'b0, "irq cleared");
      $display("test software strobe done");
   endtask
   task automatic t_timer();
      logic [7:0] v;
      din = 1'b0;
      reg_write(ctrl_a, 8'h14);
      reg_write(stat_a, 8'hE0);
      reg_write(data_a, 8'h01);
      tmr = 1'b1;
      pause(1);
      tmr = 1'b0;
      reg_read(data_a, v);
      check8(v, 8'h02, "timer shift");
      chk_stat(8'h01, "timer count");
      addr = data_a;
      wdata = 8'h55;
      wr = 1'b1;
      tmr = 1'b1;
      pause(1);
      wr = 1'b0;
      tmr = 1'b0;
      reg_read(data_a, v);
      check8(v, 8'h55, "write beats shift");
      $display("test timer done");
   endtask
   task automatic t_ext();
      logic [7:0] v;
      din = 1'b1;
      reg_write(ctrl_a, 8'h18);
      reg_write(data_a, 8'h00);
      reg_write(stat_a, 8'hE0);
      m.scl_low();
      m.scl_high(ok);
      reg_read(data_a, v);
      check8(v, 8'h01, "pin clock shift");
      chk_stat(8'h82, "edges and start");
      reg_write(stat_a, 8'h82);
      chk_stat(8'h02, "start cleared");
      // Strobe select on external clock: only toggle strobes count, pin edges do not set start
      reg_write(stat_a, 8'hE0);
      reg_write(ctrl_a, 8'h1A);
      repeat (2) reg_write(ctrl_a, 8'h1B);
      pause(4);
      chk_stat(8'h02, "toggle strobe count");
      reg_read(data_a, v);
      check8(v, 8'h03, "toggled pin shift");
      $display("test external clock done");
   endtask
   task automatic t_off();
      // Internal clock keeps the latch open, so the all-ones byte reaches it before two-wire mode
      reg_write(ctrl_a, 8'h00);
      reg_write(data_a, 8'hFF);
      reg_write(stat_a, 8'hE0);
      m.set_sda(1'b0);
      m.set_sda(1'b1);
      chk_stat(8'h00, "detector off");
      check1(dout_oe | sda_oe | scl_oe, 1'b0, "outputs off");
      $display("test mode off done");
   endtask
   task automatic t_two();
      logic [7:0] v;
      reg_write(ctrl_a, 8'hF8);
      tw = 1'b1;
      wake_seen = 1'b0;
      m.set_sda(1'b0);
      chk_stat(8'h80, "start seen");
      check1(wake_seen, 1'b1, "wake pulse");
      check1(irq, 1'b1, "start irq");
      m.scl_low();
      m.scl_high(ok);
      check1(ok, 1'b0, "start hold");
      m.scl_low();
      reg_write(stat_a, 8'h80);
      pause(2);
      check1(scl_oe & ~scl_po, 1'b0, "hold released");
      v = 8'hC5;
      for (int i = 7; i >= 0; i--)
         m.send_bit(v[i], ok);
      reg_read(data_a, v);
      check8(v, 8'hC5, "byte in");
      chk_stat(8'h40, "byte wrap");
      check1(scl_oe & ~scl_po, 1'b1, "overflow hold");
      reg_write(stat_a, 8'h4E);
      m.send_bit(1'b0, ok);
      check1(ok, 1'b1, "ack clock free");
      chk_stat(8'h40, "ack wrap");
      reg_write(stat_a, 8'h40);
      m.set_sda(1'b0);
      reg_read(stat_a, v);
      check1(v[4], 1'b1, "collision");
      reg_write(data_a, 8'hFF);
      m.scl_high(ok);
      m.set_sda(1'b1);
      chk_stat(8'h21, "stop seen");
      check1(irq, 1'b0, "stop no irq");
      $display("test two-wire done");
   endtask

   // Main sequence: reset, then each scenario in turn
   initial
   begin
      repeat (5) @(posedge mclk);
      #1;
      reset_n = 1'b1;
      t_reset();
      t_soft();
      t_timer();
      t_ext();
      t_off();
      t_two();
      end_sim();
   end
endmodule
